/* bench/ext_bus_asserts.sv */
`default_nettype none
module ext_bus_asserts (
   input wire logic i_ref_clk, // Core clock
   input wire logic i_reset, // Sync reset
   input wire logic o_busy, // Access running
   input wire logic o_rd_valid, // Read word pulse
   input wire logic [15:0] o_ext_word_addr, // Address pins
   input wire logic o_program_space_select_n, // Program select
   input wire logic o_data_space_select_n, // Data select
   input wire logic o_read_strobe_n, // Read strobe
   input wire logic o_write_strobe_n, // Write strobe
   input wire logic o_ext_bus_word_oe // Data drive enable
);
   timeunit 1ns;
   timeprecision 1ps;
   wire logic rd = !o_read_strobe_n;
   wire logic wr = !o_write_strobe_n;
   wire logic ps = !o_program_space_select_n;
   wire logic ds = !o_data_space_select_n;
   wire logic oe = o_ext_bus_word_oe;
   wire logic [17:0] qual = {o_ext_word_addr, ps, ds};
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_reset);
   a_idle_off: assert property (!o_busy |-> !oe)
      else $error("bus driven while idle");
   a_read_off: assert property (rd |-> !oe)
      else $error("bus driven in read");
   a_write_on: assert property (wr |-> oe)
      else $error("bus not driven in write");
   a_strobe_excl: assert property (!(rd && wr))
      else $error("both strobes low");
   a_sel_both: assert property (!(ps && ds))
      else $error("both selects low");
   a_strobe_sel: assert property ((rd || wr) |-> ps ^ ds)
      else $error("strobe without one select");
   a_rd_stable: assert property (rd ##1 rd |-> $stable(qual))
      else $error("address moved in read");
   a_wr_stable: assert property (wr ##1 wr |-> $stable(qual))
      else $error("address moved in write");
   a_read_capture: assert property ($fell(rd) |-> ##2 o_rd_valid)
      else $error("no read word after strobe rise");
   a_rd_len: assert property ($rose(rd) |=> rd ##1 !rd)
      else $error("read strobe length");
   a_wr_len: assert property ($rose(wr) |=> wr ##1 !wr)
      else $error("write strobe length");
   a_sel_idle: assert property (!o_busy |-> !(ps || ds))
      else $error("select low while idle");
   a_rd_pulse: assert property (o_rd_valid |=> !o_rd_valid)
      else $error("read word pulse too long");
endmodule
bind external_memory_bus_port ext_bus_asserts u_chk (.*);
`default_nettype wire

/* bench/ext_sram_model.sv */
`default_nettype none
// Program and data space share one array, split by the top key bit
module ext_sram_model (
   input wire logic [15:0] i_addr, // Word address
   input wire logic i_ps_n, // Program select
   input wire logic i_ds_n, // Data select
   input wire logic i_oe_n, // Output enable
   input wire logic i_we_n, // Write enable
   input wire logic [15:0] i_bus, // Resolved bus
   output logic [15:0] o_bus // Memory drive
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] mem [0:131071];
   logic [15:0] park = 16'ha5a5;
   wire logic [16:0] key = {!i_ds_n, i_addr};
   wire logic sel = !(i_ps_n && i_ds_n);
   always @(posedge i_we_n) if (sel) mem[key] = i_bus;
   // No pull on the bus: a released bus must never echo the last word
   always @(posedge i_oe_n) park = ~park;
   assign o_bus = (!i_oe_n && sel) ? mem[key] : park;
endmodule
`default_nettype wire

/* bench/external_memory_bus_port_tb_top.sv */
`default_nettype none
module external_memory_bus_port_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst = 1'b1, vld = 1'b0, wr = 1'b0, dsp = 1'b0;
   logic [15:0] addr = 16'h0000, wd = 16'h0000, rd, pa, dout, mout;
   logic rdy, rv, busy, ps_n, ds_n, rs_n, ws_n, oe;
   wire logic [15:0] bus = oe ? dout : mout;
   int failures = 0, tests_run = 0, cyc = 0;
   always #4 clk = ~clk;
   external_memory_bus_port u_dut (.i_ref_clk(clk), .i_reset(rst),
      .i_req_valid(vld), .o_req_ready(rdy), .i_req_write(wr),
      .i_req_data_space(dsp), .i_req_addr(addr), .i_req_wdata(wd),
      .o_rd_valid(rv), .o_rd_data(rd), .o_busy(busy), .o_ext_word_addr(pa),
      .o_program_space_select_n(ps_n), .o_data_space_select_n(ds_n),
      .o_read_strobe_n(rs_n), .o_write_strobe_n(ws_n),
      .i_ext_bus_word(bus), .o_ext_bus_word(dout), .o_ext_bus_word_oe(oe));
   ext_sram_model u_mem (.i_addr(pa), .i_ps_n(ps_n), .i_ds_n(ds_n),
      .i_oe_n(rs_n), .i_we_n(ws_n), .i_bus(bus), .o_bus(mout));
   task summarize();
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         failures++;
         summarize();
      end
   end
   task chk(input string n, input logic [15:0] e, g);
      tests_run++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task req(input logic w, s, input logic [15:0] a, d);
      int n;
      n = 0;
      @(negedge clk);
      {vld, wr, dsp, addr, wd} = {1'b1, w, s, a, d};
      // Ready is looked at away from the edge that takes the request
      while (rdy !== 1'b1 && n < 20) begin
         @(negedge clk);
         n++;
      end
      chk("ready", 16'h0001, {15'h0000, rdy});
      @(negedge clk);
      vld = 1'b0;
   endtask
   task get(input logic [15:0] e);
      int n;
      n = 0;
      while (rv !== 1'b1 && n < 20) begin
         @(negedge clk);
         n++;
      end
      chk("rd_valid", 16'h0001, {15'h0000, rv});
      chk("rdata", e, rd);
      @(negedge clk);
   endtask
   // Write or read one word, judging the pins while the strobe is low
   task acc(input logic w, s, input logic [15:0] a, d);
      int n;
      n = 0;
      req(w, s, a, d);
      while (rs_n && ws_n && n < 20) begin
         @(negedge clk);
         n++;
      end
      chk("addr", a, pa);
      chk("strobes", {14'h0000, w, !w}, {14'h0000, rs_n, ws_n});
      chk("oe", {15'h0000, w}, {15'h0000, oe});
      chk("sel", {14'h0000, s, !s}, {14'h0000, ps_n, ds_n});
      if (w) chk("wdata", d, dout);
      else get(d);
   endtask
   task idle();
      repeat (4) @(negedge clk);
      chk("idle_oe", 16'h0000, {15'h0000, oe | busy});
   endtask
   task t_spaces();
      acc(1'b1, 1'b0, 16'h1234, 16'hbeef);
      acc(1'b1, 1'b1, 16'h1234, 16'h0f0f);
      acc(1'b0, 1'b0, 16'h1234, 16'hbeef);
      acc(1'b0, 1'b1, 16'h1234, 16'h0f0f);
      idle();
      $display("t_spaces done");
   endtask
   task t_edges();
      acc(1'b1, 1'b1, 16'hffff, 16'hffff);
      acc(1'b1, 1'b0, 16'h0000, 16'h5555);
      req(1'b0, 1'b1, 16'hffff, 16'h0000);
      req(1'b0, 1'b0, 16'h0000, 16'h0000);
      get(16'hffff);
      get(16'h5555);
      idle();
      $display("t_edges done");
   endtask
   initial begin
      repeat (8) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      t_spaces();
      t_edges();
      summarize();
   end
endmodule
`default_nettype wire

/* hdl/ext_mem_pkg.sv */
`default_nettype none
package ext_mem_pkg;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned ADDR_W = 16;
   // Strobe low time and idle setup/hold around it, in core cycles
   localparam int unsigned SETUP_CYC = 1;
   localparam int unsigned STROBE_CYC = 2;
   localparam int unsigned HOLD_CYC = 1;
   localparam int unsigned CNT_W = 4;
   localparam logic [15:0] ADDR_RST = 16'h0000;
   localparam logic [15:0] DATA_RST = 16'h0000;
   typedef enum logic [1:0] {SP_PROGRAM, SP_DATA} space_e;
endpackage
`default_nettype wire

/* hdl/ext_mem_req_if.sv */
`default_nettype none
interface ext_mem_req_if;
   import ext_mem_pkg::*;
   logic valid;
   logic ready;
   logic write;
   logic data_space;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   modport src (output valid, write, data_space, addr, wdata, input ready);
   modport snk (input valid, write, data_space, addr, wdata, output ready);
endinterface
`default_nettype wire

/* hdl/ext_mem_req_stage.sv */
`default_nettype none
// Holds one request until the bus sequencer takes it
module ext_mem_req_stage
   import ext_mem_pkg::*;
(
   input wire logic i_ref_clk,              // Core clock
   input wire logic i_reset,                // Sync reset, high
   input wire logic i_valid,                // Request offered
   output logic o_ready,                    // Stage can take it
   input wire logic i_write,                // 1 write, 0 read
   input wire logic i_data_space,           // 1 data, 0 program
   input wire logic [ADDR_W-1:0] i_addr,    // Word address
   input wire logic [DATA_W-1:0] i_wdata,   // Write word
   ext_mem_req_if.src req                   // To sequencer
);
   typedef struct packed {
      logic full;
      logic write;
      logic data_space;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } stage_s;
   stage_s st_ff, nxt_st;

   assign o_ready = !st_ff.full;
   assign req.valid = st_ff.full;
   assign req.write = st_ff.write;
   assign req.data_space = st_ff.data_space;
   assign req.addr = st_ff.addr;
   assign req.wdata = st_ff.wdata;

   always_comb begin
      nxt_st = st_ff;
      if (st_ff.full && req.ready) begin
         nxt_st.full = 1'b0;
      end
      if (!st_ff.full && i_valid) begin
         nxt_st.full = 1'b1;
         nxt_st.write = i_write;
         nxt_st.data_space = i_data_space;
         nxt_st.addr = i_addr;
         nxt_st.wdata = i_wdata;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end
endmodule
`default_nettype wire

/* hdl/external_memory_bus_port.sv */
`default_nettype none
// Contract
// - Every external access carries its word on the 16-bit two-way bus.
// - Bus drivers are off whenever no external access runs.
// - Program select low for a program-space access, high otherwise.
// - Data select low for a data-space access, high otherwise.
// - Read strobe low during reads; drivers stay off meanwhile.
// - Read word is captured as the read strobe rises.
// - Address and select stay stable while read strobe is low.
// - Write strobe low during writes with drivers on and word shown.
// - Address and select stay stable while write strobe is low.
// - Write strobe only in writes, never with the read strobe.
// - A 16-bit word address is presented for every access.
module external_memory_bus_port
   import ext_mem_pkg::*;
(
   input wire logic i_ref_clk,                 // Core clock, 125 MHz
   input wire logic i_reset,                   // Sync reset, high
   input wire logic i_req_valid,               // Access request
   output logic o_req_ready,                   // Request accepted
   input wire logic i_req_write,               // 1 write, 0 read
   input wire logic i_req_data_space,          // 1 data, 0 program
   input wire logic [ADDR_W-1:0] i_req_addr,   // Word address
   input wire logic [DATA_W-1:0] i_req_wdata,  // Write word
   output logic o_rd_valid,                    // Read word ready pulse
   output logic [DATA_W-1:0] o_rd_data,        // Captured read word
   output logic o_busy,                        // Access in progress
   output logic [ADDR_W-1:0] o_ext_word_addr,  // Address pins
   output logic o_program_space_select_n,      // Program select, low
   output logic o_data_space_select_n,         // Data select, low
   output logic o_read_strobe_n,               // Read strobe, low
   output logic o_write_strobe_n,              // Write strobe, low
   input wire logic [DATA_W-1:0] i_ext_bus_word, // Data pins in
   output logic [DATA_W-1:0] o_ext_bus_word,   // Data pins out
   output logic o_ext_bus_word_oe              // Data pins drive enable
);
   typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD} phase_e;
   // Levels of the selects, strobes and drive enable; registered as one group
   typedef struct packed {
      logic ps_n;
      logic ds_n;
      logic rd_n;
      logic wr_n;
      logic oe;
   } pins_s;
   typedef struct packed {
      phase_e phase;
      logic [CNT_W-1:0] cnt;
      logic write;
      logic data_space;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      pins_s pins;
      logic [DATA_W-1:0] bus_meta;
      logic [DATA_W-1:0] bus_sync;
      logic [1:0] cap;
      logic rd_valid;
      logic [DATA_W-1:0] rd_data;
   } port_s;
   port_s st_ff, nxt_st;
   ext_mem_req_if req_bus ();

   function automatic logic [CNT_W-1:0] cycles(input int unsigned n);
      cycles = CNT_W'(n - 1);
   endfunction

   function automatic logic last_cycle(input logic [CNT_W-1:0] c);
      last_cycle = c == '0;
   endfunction

   function automatic logic [CNT_W-1:0] count_down(
      input logic [CNT_W-1:0] c
   );
      count_down = c - 1'b1;
   endfunction

   // One decode for every strobe and select, used at reset and in run
   function automatic pins_s pins_for(
      input phase_e ph,
      input logic write,
      input logic data_space
   );
      pins_s p;
      p.ps_n = 1'b1;
      p.ds_n = 1'b1;
      p.rd_n = 1'b1;
      p.wr_n = 1'b1;
      p.oe = 1'b0;
      unique case (ph)
         ST_IDLE: begin
            p.oe = 1'b0;
         end
         ST_SETUP, ST_HOLD: begin
            p.ps_n = data_space;
            p.ds_n = !data_space;
            // Drivers cover setup and hold of a write too, so the word is
            // stable on both sides of the rising write strobe
            p.oe = write;
         end
         ST_STROBE: begin
            p.ps_n = data_space;
            p.ds_n = !data_space;
            p.rd_n = write;
            p.wr_n = !write;
            p.oe = write;
         end
      endcase
      pins_for = p;
   endfunction

   // The stage lets the next request wait while one access runs
   // Phase lengths are fixed; the memory gets no wait-state programming
   ext_mem_req_stage u_stage (
      .i_ref_clk(i_ref_clk),
      .i_reset(i_reset),
      .i_valid(i_req_valid),
      .o_ready(o_req_ready),
      .i_write(i_req_write),
      .i_data_space(i_req_data_space),
      .i_addr(i_req_addr),
      .i_wdata(i_req_wdata),
      .req(req_bus.src)
   );

   logic active;
   assign active = st_ff.phase != ST_IDLE;
   assign req_bus.ready = st_ff.phase == ST_IDLE;
   assign o_busy = active;

   // Address, selects and strobes all leave flip-flops: a decode of the
   // phase could glitch a strobe and write a stray word into the memory
   assign o_ext_word_addr = st_ff.addr;
   assign o_program_space_select_n = st_ff.pins.ps_n;
   assign o_data_space_select_n = st_ff.pins.ds_n;
   assign o_read_strobe_n = st_ff.pins.rd_n;
   assign o_write_strobe_n = st_ff.pins.wr_n;
   assign o_ext_bus_word_oe = st_ff.pins.oe;
   assign o_ext_bus_word = st_ff.wdata;
   assign o_rd_valid = st_ff.rd_valid;
   assign o_rd_data = st_ff.rd_data;

   always_comb begin
      nxt_st = st_ff;
      nxt_st.rd_valid = 1'b0;
      // Data pins come from outside the clock domain: two stages, and
      // only the second stage is read. Costs two cycles of read latency.
      nxt_st.bus_meta = i_ext_bus_word;
      nxt_st.bus_sync = st_ff.bus_meta;
      nxt_st.cap = {st_ff.cap[0], 1'b0};
      unique case (st_ff.phase)
         ST_IDLE: begin
            if (req_bus.valid) begin
               nxt_st.phase = ST_SETUP;
               nxt_st.cnt = cycles(SETUP_CYC);
               nxt_st.write = req_bus.write;
               nxt_st.data_space = req_bus.data_space;
               nxt_st.addr = req_bus.addr;
               nxt_st.wdata = req_bus.wdata;
            end
         end
         ST_SETUP: begin
            if (last_cycle(st_ff.cnt)) begin
               nxt_st.phase = ST_STROBE;
               nxt_st.cnt = cycles(STROBE_CYC);
            end else begin
               nxt_st.cnt = count_down(st_ff.cnt);
            end
         end
         ST_STROBE: begin
            if (last_cycle(st_ff.cnt)) begin
               nxt_st.phase = ST_HOLD;
               nxt_st.cnt = cycles(HOLD_CYC);
               // Last strobe-low cycle: the word on the pins now is the
               // one the memory shows as the strobe goes high
               if (!st_ff.write) begin
                  nxt_st.cap[0] = 1'b1;
               end
            end else begin
               nxt_st.cnt = count_down(st_ff.cnt);
            end
         end
         ST_HOLD: begin
            if (last_cycle(st_ff.cnt)) begin
               nxt_st.phase = ST_IDLE;
            end else begin
               nxt_st.cnt = count_down(st_ff.cnt);
            end
         end
      endcase
      // Two edges later the synchronised copy of that word is in place
      if (st_ff.cap[1]) begin
         nxt_st.rd_data = st_ff.bus_sync;
         nxt_st.rd_valid = 1'b1;
      end
      nxt_st.pins = pins_for(nxt_st.phase, nxt_st.write, nxt_st.data_space);
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         st_ff <= '{
            phase: ST_IDLE,
            cnt: '0,
            write: 1'b0,
            data_space: 1'b0,
            addr: ADDR_RST,
            wdata: DATA_RST,
            pins: pins_for(ST_IDLE, 1'b0, 1'b0),
            bus_meta: DATA_RST,
            bus_sync: DATA_RST,
            cap: 2'b00,
            rd_valid: 1'b0,
            rd_data: DATA_RST
         };
      end else begin
         st_ff <= nxt_st;
      end
   end
endmodule
`default_nettype wire
